// file: nalu_regs.vh
// shared constants for the nibble accumulator datapath
`ifndef NALU_REGS_VH
`define NALU_REGS_VH

// operation codes on op_code
`define NALU_OP_MEM_TO_WORK    5'h00
`define NALU_OP_WORK_TO_MEM    5'h01
`define NALU_OP_SHR_ZERO       5'h02
`define NALU_OP_SHR_ONE        5'h03
`define NALU_OP_SHL_ZERO       5'h04
`define NALU_OP_SHL_ONE        5'h05
`define NALU_OP_CARRY_FROM_MSB 5'h06
`define NALU_OP_FLAGS_TO_MEM   5'h07
`define NALU_OP_INC            5'h08
`define NALU_OP_DEC            5'h09
`define NALU_OP_ADC            5'h0A
`define NALU_OP_SUB_BORROW     5'h0B
`define NALU_OP_ADD            5'h0C
`define NALU_OP_SUB            5'h0D
`define NALU_OP_ADD_KEEP       5'h0E
`define NALU_OP_AND            5'h0F
`define NALU_OP_LOAD_PTR_HIGH  5'h10
`define NALU_OP_LOAD_PTR_LOW   5'h11

// working register window base (upper three address bits)
`define NALU_WORK_BASE_HI      3'h7

// flag nibble field positions
`define NALU_FLAG_CARRY_BIT    3
`define NALU_FLAG_ZERO_BIT     2

// reset values
`define NALU_ACC_RESET         4'h0
`define NALU_CARRY_RESET       1'b0
`define NALU_MEM_RESET         4'h0
`define NALU_PTR_RESET         8'h00

`endif

// file: nalu_adder.v
// four-bit adder with carry in and carry out
`timescale 1ns/1ns

module nalu_adder #(
	parameter W = 4
) (
	// operands
	input  wire [W-1:0] a,
	input  wire [W-1:0] b,
	input  wire         cin,
	// result
	output wire [W-1:0] sum,
	output wire         cout
);

	wire [W:0] full;

	assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
	assign sum  = full[W-1:0];
	assign cout = full[W];

endmodule // nalu_adder

// file: nalu_index.v
// eight-bit index pointer, loaded one nibble at a time
`timescale 1ns/1ns
`include "nalu_regs.vh"

module nalu_index (
	// clock and reset
	input  wire       clk,
	input  wire       reset_n,
	input  wire       clk_en,
	// nibble loads
	input  wire       load_high,
	input  wire       load_low,
	input  wire [3:0] nibble,
	// pointer
	output reg  [7:0] ptr
);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr <= `NALU_PTR_RESET;
		end else if (clk_en) begin
			if (load_high) begin
				ptr[7:4] <= nibble;
			end
			if (load_low) begin
				ptr[3:0] <= nibble;
			end
		end
	end

endmodule // nalu_index

// file: nalu_core.v
// accumulator datapath with local data memory, moves, shifts and arithmetic
`timescale 1ns/1ns
`include "nalu_regs.vh"

//=============================================================
module nalu_core #(
	parameter AW    = 7,
	parameter DEPTH = 128
) (
	// clock and reset
	input  wire          clk,
	input  wire          reset_n,
	input  wire          clk_en,
	// operation request from decoder
	input  wire          op_valid,
	input  wire [4:0]    op_code,
	input  wire          op_indirect,
	input  wire          op_store,
	input  wire [AW-1:0] op_direct_addr,
	input  wire [3:0]    working_register_selector,
	// side port into data memory
	input  wire          ext_wr_en,
	input  wire [AW-1:0] ext_addr,
	input  wire [3:0]    ext_wr_data,
	output reg  [3:0]    ext_rd_data,
	// datapath state
	output reg  [3:0]    main_operand_register,
	output reg           carry_bit,
	output wire [7:0]    index_pointer,
	output reg           op_done
);

	//=============================================================
	// helpers

	function [AW-1:0] work_addr;
		input [3:0] sel;
		begin
			work_addr = {`NALU_WORK_BASE_HI, sel};
		end
	endfunction

	function is_alu_op;
		input [4:0] code;
		begin
			is_alu_op = (code >= `NALU_OP_INC) && (code <= `NALU_OP_AND);
		end
	endfunction

	//=============================================================
	// storage and signals

	reg  [3:0]    mem [0:DEPTH-1];
	reg  [AW-1:0] src_addr;
	reg  [AW-1:0] dst_addr;
	wire [3:0]    src_data;
	wire [AW-1:0] ptr_addr;
	wire          fire;
	reg  [3:0]    add_b;
	reg           add_cin;
	wire [3:0]    add_sum;
	wire          add_cout;
	reg  [3:0]    next_result;
	reg           next_carry;
	reg           mem_we;
	reg           acc_we;
	reg           carry_we;
	reg           load_high;
	reg           load_low;
	integer       i;

	assign fire     = op_valid && clk_en;
	// pointer bits above the memory depth are ignored
	assign ptr_addr = index_pointer[AW-1:0];
	assign src_data = mem[src_addr];

	//=============================================================
	// operand addressing

	always @* begin
		src_addr = op_direct_addr;
		dst_addr = op_direct_addr;
		case (op_code)
			`NALU_OP_MEM_TO_WORK: begin
				dst_addr = op_indirect ? ptr_addr : work_addr(working_register_selector);
			end
			`NALU_OP_WORK_TO_MEM: begin
				src_addr = op_indirect ? ptr_addr : work_addr(working_register_selector);
			end
			default: begin
				if (is_alu_op(op_code) && op_indirect) begin
					src_addr = ptr_addr;
					dst_addr = ptr_addr;
				end
			end
		endcase
	end

	//=============================================================
	// adder operand selection

	always @* begin
		add_b   = main_operand_register;
		add_cin = 1'b0;
		case (op_code)
			`NALU_OP_INC: begin
				add_b   = 4'h0;
				add_cin = 1'b1;
			end
			`NALU_OP_DEC: begin
				// minus one as plus all ones, so carry set means no borrow
				add_b   = 4'hF;
				add_cin = 1'b0;
			end
			`NALU_OP_ADC: begin
				add_cin = carry_bit;
			end
			`NALU_OP_SUB_BORROW: begin
				add_b   = ~main_operand_register;
				add_cin = carry_bit;
			end
			`NALU_OP_SUB: begin
				add_b   = ~main_operand_register;
				add_cin = 1'b1;
			end
			default: begin
				add_b   = main_operand_register;
				add_cin = 1'b0;
			end
		endcase
	end

	nalu_adder #(
		.W    (4)
	) u_adder (
		.a    (src_data),
		.b    (add_b),
		.cin  (add_cin),
		.sum  (add_sum),
		.cout (add_cout)
	);

	//=============================================================
	// result and write enables

	always @* begin
		next_result = src_data;
		next_carry  = carry_bit;
		mem_we      = 1'b0;
		acc_we      = 1'b0;
		carry_we    = 1'b0;
		load_high   = 1'b0;
		load_low    = 1'b0;
		case (op_code)
			`NALU_OP_MEM_TO_WORK, `NALU_OP_WORK_TO_MEM: begin
				next_result = src_data;
				mem_we      = 1'b1;
				acc_we      = 1'b1;
			end
			`NALU_OP_SHR_ZERO: begin
				next_result = {1'b0, src_data[3:1]};
				mem_we      = 1'b1;
				acc_we      = 1'b1;
			end
			`NALU_OP_SHR_ONE: begin
				next_result = {1'b1, src_data[3:1]};
				mem_we      = 1'b1;
				acc_we      = 1'b1;
			end
			`NALU_OP_SHL_ZERO: begin
				next_result = {src_data[2:0], 1'b0};
				mem_we      = 1'b1;
				acc_we      = 1'b1;
			end
			`NALU_OP_SHL_ONE: begin
				next_result = {src_data[2:0], 1'b1};
				mem_we      = 1'b1;
				acc_we      = 1'b1;
			end
			`NALU_OP_CARRY_FROM_MSB: begin
				next_carry = src_data[3];
				carry_we   = 1'b1;
			end
			`NALU_OP_FLAGS_TO_MEM: begin
				// zero test sees accumulator before the write
				next_result = 4'h0;
				next_result[`NALU_FLAG_CARRY_BIT] = carry_bit;
				next_result[`NALU_FLAG_ZERO_BIT]  = (main_operand_register == 4'h0);
				mem_we      = 1'b1;
				acc_we      = 1'b1;
			end
			`NALU_OP_INC, `NALU_OP_DEC: begin
				next_result = add_sum;
				next_carry  = add_cout;
				mem_we      = 1'b1;
				acc_we      = 1'b1;
				carry_we    = 1'b1;
			end
			`NALU_OP_ADC, `NALU_OP_SUB_BORROW, `NALU_OP_ADD, `NALU_OP_SUB: begin
				next_result = add_sum;
				next_carry  = add_cout;
				acc_we      = 1'b1;
				carry_we    = 1'b1;
				mem_we      = op_store;
			end
			`NALU_OP_ADD_KEEP: begin
				next_result = add_sum;
				acc_we      = 1'b1;
				mem_we      = op_store;
			end
			`NALU_OP_AND: begin
				next_result = src_data & main_operand_register;
				acc_we      = 1'b1;
				mem_we      = op_store;
			end
			`NALU_OP_LOAD_PTR_HIGH: begin
				load_high = 1'b1;
			end
			`NALU_OP_LOAD_PTR_LOW: begin
				load_low = 1'b1;
			end
			default: begin
				next_result = src_data;
			end
		endcase
	end

	//=============================================================
	// index pointer

	nalu_index u_index (
		.clk       (clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.load_high (load_high && op_valid),
		.load_low  (load_low && op_valid),
		.nibble    (src_data),
		.ptr       (index_pointer)
	);

	//=============================================================
	// accumulator, carry, done

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			main_operand_register <= `NALU_ACC_RESET;
			carry_bit             <= `NALU_CARRY_RESET;
			op_done               <= 1'b0;
		end else if (clk_en) begin
			op_done <= op_valid;
			if (op_valid && acc_we) begin
				main_operand_register <= next_result;
			end
			if (op_valid && carry_we) begin
				carry_bit <= next_carry;
			end
		end
	end

	//=============================================================
	// data memory

	// an operation's write wins over the side port in the same cycle
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem[i] <= `NALU_MEM_RESET;
			end
		end else if (clk_en) begin
			if (fire && mem_we) begin
				mem[dst_addr] <= next_result;
			end else if (ext_wr_en) begin
				mem[ext_addr] <= ext_wr_data;
			end
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_rd_data <= `NALU_MEM_RESET;
		end else if (clk_en) begin
			ext_rd_data <= mem[ext_addr];
		end
	end

endmodule // nalu_core

// file: nalu_core_asserts.sv
// concurrent checks on the accumulator datapath ports
`timescale 1ns/1ns

module nalu_core_asserts (
	// clock and reset
	input wire       clk,
	input wire       reset_n,
	input wire       clk_en,
	// request
	input wire       op_valid,
	input wire [4:0] op_code,
	// datapath state
	input wire [3:0] main_operand_register,
	input wire       carry_bit,
	input wire [7:0] index_pointer,
	input wire       op_done
);
	wire       go  = op_valid & clk_en;
	wire [3:0] acc = main_operand_register;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	//==========================================================
	// shifts
	property p_shr0; go && op_code == 5'h02 |=> !acc[3]; endproperty
	a_shr0: assert property (p_shr0)
		else $error("zero fill missing in bit 3");
	property p_shr1; go && op_code == 5'h03 |=> acc[3]; endproperty
	a_shr1: assert property (p_shr1)
		else $error("one fill missing in bit 3");
	property p_shl0; go && op_code == 5'h04 |=> !acc[0]; endproperty
	a_shl0: assert property (p_shl0)
		else $error("zero fill missing in bit 0");
	property p_shl1; go && op_code == 5'h05 |=> acc[0]; endproperty
	a_shl1: assert property (p_shl1)
		else $error("one fill missing in bit 0");

	//==========================================================
	// flags, carry, and-result and pointer
	property p_msb; go && op_code == 5'h06 |=> $stable(acc); endproperty
	a_msb: assert property (p_msb)
		else $error("accumulator moved on carry load");
	property p_flags;
		go && op_code == 5'h07 |=> acc == {$past(carry_bit), $past(acc) == 4'h0, 2'b00};
	endproperty
	a_flags: assert property (p_flags)
		else $error("flag nibble wrong");
	property p_keep; go && op_code == 5'h0E |=> $stable(carry_bit); endproperty
	a_keep: assert property (p_keep)
		else $error("carry changed by add keeping carry");
	property p_and; go && op_code == 5'h0F |=> (acc & ~$past(acc)) == 4'h0; endproperty
	a_and: assert property (p_and)
		else $error("and result sets a cleared bit");
	property p_ptr; go && op_code < 5'h10 |=> $stable(index_pointer); endproperty
	a_ptr: assert property (p_ptr)
		else $error("pointer changed by a non-pointer op");

	//==========================================================
	// handshake and clock enable
	property p_done; clk_en |=> op_done == $past(op_valid); endproperty
	a_done: assert property (p_done)
		else $error("done pulse does not follow the request");
	property p_freeze;
		!clk_en |=> $stable(acc) && $stable(carry_bit)
			&& $stable(index_pointer) && $stable(op_done);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");
endmodule // nalu_core_asserts

// file: nalu_dec_model.sv
// decoder and loader model that issues requests to the datapath
`timescale 1ns/1ns

module nalu_dec_model (
	// clock
	input  wire       clk,
	// operation request
	output reg        op_valid,
	output reg  [4:0] op_code,
	output reg        op_indirect,
	output reg        op_store,
	output reg  [6:0] op_direct_addr,
	output reg  [3:0] working_register_selector,
	// side port
	output reg        ext_wr_en,
	output reg  [6:0] ext_addr,
	output reg  [3:0] ext_wr_data
);
	initial begin
		{op_valid, op_code, op_indirect, op_store, op_direct_addr} = 15'h0000;
		{working_register_selector, ext_wr_en, ext_addr, ext_wr_data} = 16'h0000;
	end

	// code and address fields are inverted once released so stale values never look valid
	task issue(input [4:0] c, input i, input s, input [6:0] a, input [3:0] r);
		begin
			@(posedge clk);
			op_valid <= 1'b1;
			op_code <= c;
			op_indirect <= i;
			op_store <= s;
			op_direct_addr <= a;
			working_register_selector <= r;
			@(posedge clk);
			op_valid <= 1'b0;
			op_code <= ~c;
			op_direct_addr <= ~a;
		end
	endtask

	task poke(input [6:0] a, input [3:0] d);
		begin
			@(posedge clk);
			ext_wr_en <= 1'b1;
			ext_addr <= a;
			ext_wr_data <= d;
			@(posedge clk);
			ext_wr_en <= 1'b0;
			ext_wr_data <= ~d;
		end
	endtask

	task peek(input [6:0] a);
		begin
			@(posedge clk);
			ext_addr <= a;
			@(posedge clk);
		end
	endtask
endmodule // nalu_dec_model

// file: tb_nalu_core.sv
// self-checking bench for the accumulator datapath
`timescale 1ns/1ns

module tb_nalu_core;
	reg         clk;
	reg         reset_n;
	reg         clk_en;
	wire        op_valid, op_indirect, op_store, ext_wr_en, op_done, carry_bit;
	wire [4:0]  op_code;
	wire [6:0]  op_direct_addr, ext_addr;
	wire [3:0]  working_register_selector, ext_wr_data, ext_rd_data;
	wire [3:0]  main_operand_register;
	wire [7:0]  index_pointer;
	integer     n_fail;
	integer     compares;
	reg  [35:0] ops [0:21];
	reg  [11:0] mem_exp [0:6];

	nalu_dec_model u_dec (.clk, .op_valid, .op_code, .op_indirect, .op_store,
		.op_direct_addr, .working_register_selector, .ext_wr_en, .ext_addr, .ext_wr_data);

	nalu_core dut (.clk, .reset_n, .clk_en, .op_valid, .op_code, .op_indirect, .op_store,
		.op_direct_addr, .working_register_selector, .ext_wr_en, .ext_addr, .ext_wr_data,
		.ext_rd_data, .main_operand_register, .carry_bit, .index_pointer, .op_done);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task chk(input string nm, input [7:0] e, input [7:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("unexpected %0s: expected %h seen %h", nm, e, g);
			end
		end
	endtask

	//==========================================================
	// scenarios
	task t_pointer;
		begin
			u_dec.poke(7'h01, 4'h1);
			u_dec.poke(7'h02, 4'h9);
			u_dec.issue(5'h10, 1'b0, 1'b0, 7'h01, 4'h0);
			u_dec.issue(5'h11, 1'b0, 1'b0, 7'h02, 4'h0);
			#1;
			chk("pointer", 8'h19, index_pointer);
		end
	endtask

	// row: code, indirect, store, address, selector, accumulator, carry
	task t_ops;
		integer     k;
		reg  [35:0] r;
		begin
			u_dec.poke(7'h05, 4'hA);
			u_dec.poke(7'h08, 4'h6);
			u_dec.poke(7'h0A, 4'h7);
			for (k = 0; k < 22; k = k + 1) begin
				r = ops[k];
				u_dec.issue(r[32:28], r[24], r[20], r[18:12], r[11:8]);
				#1;
				chk("acc", {4'h0, r[7:4]}, {4'h0, main_operand_register});
				chk("carry", {7'h00, r[0]}, {7'h00, carry_bit});
				chk("done", 8'h01, {7'h00, op_done});
			end
		end
	endtask

	// a request while the clock enable is low must leave everything alone
	task t_hold;
		begin
			@(posedge clk);
			clk_en <= 1'b0;
			u_dec.issue(5'h08, 1'b0, 1'b0, 7'h0C, 4'h0);
			#1;
			chk("held acc", 8'h00, {4'h0, main_operand_register});
			chk("held carry", 8'h01, {7'h00, carry_bit});
			chk("held done", 8'h00, {7'h00, op_done});
			@(posedge clk);
			clk_en <= 1'b1;
		end
	endtask

	// mid-run reset, then a request in the second cycle after release
	task t_reset;
		begin
			@(posedge clk);
			reset_n <= 1'b0;
			@(posedge clk);
			#1;
			chk("reset acc", 8'h00, {4'h0, main_operand_register});
			chk("reset carry", 8'h00, {7'h00, carry_bit});
			chk("reset pointer", 8'h00, index_pointer);
			chk("reset done", 8'h00, {7'h00, op_done});
			@(posedge clk);
			reset_n <= 1'b1;
			u_dec.issue(5'h08, 1'b0, 1'b0, 7'h0C, 4'h0);
			#1;
			chk("inc after reset", 8'h01, {4'h0, main_operand_register});
			chk("carry after reset", 8'h00, {7'h00, carry_bit});
			chk("done after reset", 8'h01, {7'h00, op_done});
		end
	endtask

	task t_memory;
		integer k;
		begin
			for (k = 0; k < 7; k = k + 1) begin
				u_dec.peek(mem_exp[k][10:4]);
				#1;
				chk("memory", {4'h0, mem_exp[k][3:0]}, {4'h0, ext_rd_data});
			end
		end
	endtask

	task print_verdict;
		begin
			$display("compares %0d n_fail %0d", compares, n_fail);
			if (n_fail == 0 && compares > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask

	initial begin
		ops = '{
			36'h00_0_0_05_3_A_0,
			36'h00_1_0_05_0_A_0,
			36'h01_0_0_06_3_A_0,
			36'h02_0_0_08_0_3_0,
			36'h03_0_0_08_0_9_0,
			36'h04_0_0_08_0_2_0,
			36'h05_0_0_08_0_5_0,
			36'h01_1_0_05_0_A_0,
			36'h0C_0_0_0A_0_1_1,
			36'h0A_0_0_0A_0_9_0,
			36'h0D_0_1_0A_0_E_0,
			36'h0B_0_0_0A_0_F_0,
			36'h06_0_0_0A_0_F_1,
			36'h0E_0_0_0A_0_D_1,
			36'h0F_0_0_0A_0_C_1,
			36'h08_1_0_00_0_B_0,
			36'h07_0_0_0B_0_0_0,
			36'h07_0_0_0B_0_4_0,
			36'h09_0_0_0B_0_3_1,
			36'h0D_0_0_0C_0_D_0,
			36'h09_0_0_0C_0_F_0,
			36'h08_0_0_0C_0_0_1
		};
		mem_exp = '{12'h73A, 12'h19B, 12'h06A, 12'h085, 12'h0AE, 12'h0B3, 12'h0C0};
		n_fail = 0;
		compares = 0;
		reset_n = 1'b0;
		clk_en = 1'b1;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		t_pointer;
		t_ops;
		t_hold;
		t_memory;
		t_reset;
		print_verdict;
	end

	// watchdog: the full run needs about 90 cycles
	initial begin
		repeat (3000) @(posedge clk);
		n_fail = n_fail + 1;
		print_verdict;
	end
endmodule // tb_nalu_core

bind nalu_core nalu_core_asserts u_chk (.clk, .reset_n, .clk_en, .op_valid, .op_code,
	.main_operand_register, .carry_bit, .index_pointer, .op_done);
